// ===== design/irq_ctrl_cfg.svh
// constants for the two-level interrupt controller
`ifndef IRQ_CTRL_CFG_SVH
`define IRQ_CTRL_CFG_SVH

`define IRQ_PC_W 21
`define IRQ_VEC_HIGH 21'h000008
`define IRQ_VEC_LOW 21'h000018
`define IRQ_NUM_SRC 8
`define IRQ_NUM_PIN 2
`define IRQ_ADDR_W 3
`define IRQ_DATA_W 8

`define IRQ_OFS_REQ_CTRL 3'h0
`define IRQ_OFS_RST_CTRL 3'h1
`define IRQ_OFS_FLAG 3'h2
`define IRQ_OFS_ENABLE 3'h3
`define IRQ_OFS_PRIORITY 3'h4
`define IRQ_OFS_STATUS 3'h5

`define IRQ_BIT_GIE_HIGH 7
`define IRQ_BIT_GIE_LOW 6
`define IRQ_BIT_PRIO_EN 7
`define IRQ_BIT_ST_HIGH 0
`define IRQ_BIT_ST_LOW 1

`define IRQ_RST_FLAG 8'h00
`define IRQ_RST_ENABLE 8'h00
`define IRQ_RST_PRIORITY 8'hFF
`define IRQ_PERIPH_MASK 8'hFC

`endif

// ===== design/irq_ctrl_pkg.sv
// types for the two-level interrupt controller
package irq_ctrl_pkg;

  typedef enum logic [3:0] {
    HS_IDLE = 4'h1,
    HS_LOW = 4'h2,
    HS_HIGH = 4'h4,
    HS_HIGH_OVER_LOW = 4'h8
  } handler_state_t;

endpackage

// ===== design/two_level_irq_ctrl.sv
// two-level interrupt controller: flags, enables, priorities and core vectoring
// Function
// - high requests vector to 000008h, low requests to 000018h
// - a high request may preempt a running low handler
// - each source has a flag, an enable and a priority bit
// - two levels work only while priority_levels_enable (bit 7) is set
// - with levels: bit 7 gates high sources, bit 6 gates low sources
// - flag, enable and global enable set vectors by priority bit
// - priority_levels_enable resets to zero: compatibility mode
// - in compatibility mode priority bits are ignored
// - compatibility: bit 6 gates peripherals, bit 7 gates everything
// - compatibility mode always vectors to 000008h
// - acceptance clears the governing global enable
// - no low request accepted while a high handler runs
// - vectoring pushes the return address and loads the vector
// - return from handler sets the enable cleared on entry
// - pin events vector four to five instruction cycles later
// - latency can grow by one cycle while a two-cycle instruction runs
// - flags set regardless of any enable
// - a cleared source enable blocks vectoring, flag still records
// - flags stay readable and stable until cleared
//
// The address-and-strobe port and the register offsets were decided locally.
`timescale 1ns/100ps
`include "irq_ctrl_cfg.svh"

module two_level_irq_ctrl (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic ce_i,
  input wire logic [`IRQ_ADDR_W-1:0] reg_addr_i,
  input wire logic [`IRQ_DATA_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [`IRQ_DATA_W-1:0] reg_rdata_o,
  input wire logic [`IRQ_NUM_PIN-1:0] ext_pin_i,
  input wire logic [`IRQ_NUM_SRC-1:0] periph_event_i,
  input wire logic instr_boundary_i,
  input wire logic [`IRQ_PC_W-1:0] return_addr_i,
  input wire logic return_from_handler_i,
  output logic vector_take_o,
  output logic [`IRQ_PC_W-1:0] vector_addr_o,
  output logic push_o,
  output logic [`IRQ_PC_W-1:0] push_data_o
);

  logic gie_high_q;
  logic gie_low_q;
  logic prio_en_q;
  logic [`IRQ_NUM_SRC-1:0] flag_q;
  logic [`IRQ_NUM_SRC-1:0] enable_q;
  logic [`IRQ_NUM_SRC-1:0] priority_q;
  logic [`IRQ_NUM_SRC-1:0] flag_d;
  logic [`IRQ_NUM_SRC-1:0] src_event;
  logic [`IRQ_NUM_PIN-1:0] pin_s1_q;
  logic [`IRQ_NUM_PIN-1:0] pin_s2_q;
  logic [`IRQ_NUM_PIN-1:0] pin_s3_q;
  logic [`IRQ_NUM_PIN-1:0] pin_level_q;
  logic [`IRQ_NUM_PIN-1:0] pin_rise;
  logic [`IRQ_DATA_W-1:0] rdata_q;
  logic [`IRQ_PC_W-1:0] vec_addr_q;
  logic [`IRQ_PC_W-1:0] push_data_q;
  logic take_q;
  irq_ctrl_pkg::handler_state_t hs_q;
  irq_ctrl_pkg::handler_state_t hs_d;
  logic [`IRQ_NUM_SRC-1:0] armed;
  logic high_req;
  logic low_req;
  logic accept;
  logic accept_high;
  logic ret;
  logic in_high;
  logic in_low;
  logic wr_ctrl;
  logic wr_rst;

  assign wr_ctrl = reg_wr_i && (reg_addr_i == `IRQ_OFS_REQ_CTRL);
  assign wr_rst = reg_wr_i && (reg_addr_i == `IRQ_OFS_RST_CTRL);

  // pin synchroniser: a change counts once stages two and three agree
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
      pin_s3_q <= '0;
    end else if (ce_i) begin
      pin_s1_q <= ext_pin_i;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
    end
  end

  genvar gp;
  generate
    for (gp = 0; gp < `IRQ_NUM_PIN; gp = gp + 1) begin : g_pin
      always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
          pin_level_q[gp] <= 1'b0;
        end else if (ce_i && (pin_s2_q[gp] == pin_s3_q[gp])) begin
          pin_level_q[gp] <= pin_s3_q[gp];
        end
      end
      // rising edge of the filtered level is the pin event
      assign pin_rise[gp] = (pin_s2_q[gp] == pin_s3_q[gp]) && pin_s3_q[gp]
                            && !pin_level_q[gp];
    end
  endgenerate

  // sources 0..1 are the pins, the rest are peripheral events
  assign src_event = {periph_event_i[`IRQ_NUM_SRC-1:`IRQ_NUM_PIN], pin_rise};

  // per-source flag: event set wins over a software clear in the same cycle
  genvar gf;
  generate
    for (gf = 0; gf < `IRQ_NUM_SRC; gf = gf + 1) begin : g_flag
      always_comb begin
        if (reg_wr_i && (reg_addr_i == `IRQ_OFS_FLAG)) begin
          flag_d[gf] = reg_wdata_i[gf] | src_event[gf];
        end else begin
          flag_d[gf] = flag_q[gf] | src_event[gf];
        end
      end
    end
  endgenerate

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      flag_q <= `IRQ_RST_FLAG;
    end else if (ce_i) begin
      flag_q <= flag_d;
    end
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      enable_q <= `IRQ_RST_ENABLE;
      priority_q <= `IRQ_RST_PRIORITY;
    end else if (ce_i && reg_wr_i) begin
      if (reg_addr_i == `IRQ_OFS_ENABLE) begin
        enable_q <= reg_wdata_i;
      end
      if (reg_addr_i == `IRQ_OFS_PRIORITY) begin
        priority_q <= reg_wdata_i;
      end
    end
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      prio_en_q <= 1'b0;
    end else if (ce_i && wr_rst) begin
      prio_en_q <= reg_wdata_i[`IRQ_BIT_PRIO_EN];
    end
  end

  // a source is armed only with its flag and its own enable
  assign armed = flag_q & enable_q;

  assign in_high = (hs_q == irq_ctrl_pkg::HS_HIGH)
                   || (hs_q == irq_ctrl_pkg::HS_HIGH_OVER_LOW);
  assign in_low = (hs_q == irq_ctrl_pkg::HS_LOW);

  always_comb begin
    if (prio_en_q) begin
      high_req = gie_high_q && |(armed & priority_q);
      low_req = gie_low_q && !in_high && |(armed & ~priority_q);
    end else begin
      // compatibility: priority bits play no part
      high_req = gie_high_q && |(armed & (~`IRQ_PERIPH_MASK
                 | ({`IRQ_NUM_SRC{gie_low_q}} & `IRQ_PERIPH_MASK)));
      low_req = 1'b0;
    end
  end

  // requests are only looked at on an instruction boundary, so the wait
  // grows by one cycle when the current instruction takes two
  assign accept = ce_i && instr_boundary_i && (high_req || low_req);
  assign accept_high = high_req;
  assign ret = ce_i && return_from_handler_i && !accept;

  always_comb begin
    hs_d = hs_q;
    unique case (hs_q)
      irq_ctrl_pkg::HS_IDLE: begin
        if (accept) begin
          hs_d = accept_high ? irq_ctrl_pkg::HS_HIGH : irq_ctrl_pkg::HS_LOW;
        end
      end
      irq_ctrl_pkg::HS_LOW: begin
        if (accept && accept_high) begin
          hs_d = irq_ctrl_pkg::HS_HIGH_OVER_LOW;
        end else if (ret) begin
          hs_d = irq_ctrl_pkg::HS_IDLE;
        end
      end
      irq_ctrl_pkg::HS_HIGH: begin
        if (ret) begin
          hs_d = irq_ctrl_pkg::HS_IDLE;
        end
      end
      irq_ctrl_pkg::HS_HIGH_OVER_LOW: begin
        if (ret) begin
          hs_d = irq_ctrl_pkg::HS_LOW;
        end
      end
      default: begin
        hs_d = irq_ctrl_pkg::HS_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      hs_q <= irq_ctrl_pkg::HS_IDLE;
    end else if (ce_i) begin
      hs_q <= hs_d;
    end
  end

  // global enables: hardware clear on entry and set on return beat software
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      gie_high_q <= 1'b0;
      gie_low_q <= 1'b0;
    end else if (ce_i) begin
      if (accept && accept_high) begin
        gie_high_q <= 1'b0;
      end else if (ret && in_high) begin
        gie_high_q <= 1'b1;
      end else if (wr_ctrl) begin
        gie_high_q <= reg_wdata_i[`IRQ_BIT_GIE_HIGH];
      end
      if (accept && !accept_high) begin
        gie_low_q <= 1'b0;
      end else if (ret && in_low) begin
        gie_low_q <= 1'b1;
      end else if (wr_ctrl) begin
        gie_low_q <= reg_wdata_i[`IRQ_BIT_GIE_LOW];
      end
    end
  end

  // core vectoring, one cycle after the boundary that accepted
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      take_q <= 1'b0;
      vec_addr_q <= '0;
      push_data_q <= '0;
    end else if (ce_i) begin
      take_q <= accept;
      if (accept) begin
        vec_addr_q <= accept_high ? `IRQ_VEC_HIGH : `IRQ_VEC_LOW;
        push_data_q <= return_addr_i;
      end
    end
  end

  assign vector_take_o = take_q;
  assign push_o = take_q;
  assign vector_addr_o = vec_addr_q;
  assign push_data_o = push_data_q;

  // read data stands in the cycle after the strobe only
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_q <= '0;
    end else if (ce_i) begin
      rdata_q <= '0;
      if (reg_rd_i) begin
        unique case (reg_addr_i)
          `IRQ_OFS_REQ_CTRL: begin
            rdata_q[`IRQ_BIT_GIE_HIGH] <= gie_high_q;
            rdata_q[`IRQ_BIT_GIE_LOW] <= gie_low_q;
          end
          `IRQ_OFS_RST_CTRL: begin
            rdata_q[`IRQ_BIT_PRIO_EN] <= prio_en_q;
          end
          `IRQ_OFS_FLAG: begin
            rdata_q <= flag_q;
          end
          `IRQ_OFS_ENABLE: begin
            rdata_q <= enable_q;
          end
          `IRQ_OFS_PRIORITY: begin
            rdata_q <= priority_q;
          end
          `IRQ_OFS_STATUS: begin
            rdata_q[`IRQ_BIT_ST_HIGH] <= in_high;
            rdata_q[`IRQ_BIT_ST_LOW] <= in_low || (hs_q == irq_ctrl_pkg::HS_HIGH_OVER_LOW);
          end
          default: begin
            rdata_q <= '0;
          end
        endcase
      end
    end
  end

  assign reg_rdata_o = rdata_q;

endmodule

// ===== verif/irq_ctrl_monitor.sv
// port checker for the two-level interrupt controller
`timescale 1ns/100ps
`include "irq_ctrl_cfg.svh"
module irq_ctrl_monitor (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic ce_i,
  input wire logic [`IRQ_ADDR_W-1:0] reg_addr_i,
  input wire logic [`IRQ_DATA_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [`IRQ_DATA_W-1:0] reg_rdata_o,
  input wire logic [`IRQ_NUM_PIN-1:0] ext_pin_i,
  input wire logic [`IRQ_NUM_SRC-1:0] periph_event_i,
  input wire logic instr_boundary_i,
  input wire logic [`IRQ_PC_W-1:0] return_addr_i,
  input wire logic return_from_handler_i,
  input wire logic vector_take_o,
  input wire logic [`IRQ_PC_W-1:0] vector_addr_o,
  input wire logic push_o,
  input wire logic [`IRQ_PC_W-1:0] push_data_o
);
  logic [7:0] lvl_q, en_q, pri_q, sh;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);
  // shadows only of registers that hardware never changes by itself
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      lvl_q <= 8'h00;
      en_q <= `IRQ_RST_ENABLE;
      pri_q <= `IRQ_RST_PRIORITY;
    end else if (ce_i && reg_wr_i) begin
      // only the priority level switch is held in this register
      if (reg_addr_i == `IRQ_OFS_RST_CTRL) lvl_q <= reg_wdata_i & 8'h80;
      if (reg_addr_i == `IRQ_OFS_ENABLE) en_q <= reg_wdata_i;
      if (reg_addr_i == `IRQ_OFS_PRIORITY) pri_q <= reg_wdata_i;
    end
  end
  always_comb begin
    case (reg_addr_i)
      `IRQ_OFS_RST_CTRL: sh = lvl_q;
      `IRQ_OFS_ENABLE: sh = en_q;
      `IRQ_OFS_PRIORITY: sh = pri_q;
      default: sh = 8'h00;
    endcase
  end
  sequence take_s;
    vector_take_o;
  endsequence
  sequence rd_s;
    ce_i && reg_rd_i && reg_addr_i inside {3'h1, 3'h3, 3'h4, 3'h6, 3'h7};
  endsequence
  push_pair_a: assert property (push_o == vector_take_o)
    else $error("push and vector load disagree");
  vec_cause_a: assert property (take_s |-> $past(instr_boundary_i))
    else $error("vector load without boundary");
  push_addr_a: assert property (take_s |-> push_data_o == $past(return_addr_i))
    else $error("wrong return address pushed");
  compat_vec_a: assert property (take_s ##0 !$past(lvl_q[7]) |->
    vector_addr_o == `IRQ_VEC_HIGH) else $error("compatibility vector wrong");
  low_vec_a: assert property (take_s ##0 vector_addr_o == `IRQ_VEC_LOW |->
    $past(lvl_q[7]) && |$past(en_q & ~pri_q)) else $error("low vector without source");
  high_lvl_a: assert property (take_s ##0 $past(lvl_q[7]) ##0
    vector_addr_o == `IRQ_VEC_HIGH |-> |$past(en_q & pri_q)) else $error("bad high vector");
  en_gate_a: assert property (take_s |-> $past(en_q) != 8'h00)
    else $error("vector with every source disabled");
  reg_read_a: assert property (rd_s |=> reg_rdata_o == $past(sh))
    else $error("register read back wrong");
endmodule
bind two_level_irq_ctrl irq_ctrl_monitor u_irq_ctrl_monitor (.*);

// ===== verif/core_model.sv
// behavioural core: instruction boundaries, program counter, stack depth
`timescale 1ns/100ps
`include "irq_ctrl_cfg.svh"
module core_model (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic two_cycle_i,
  input wire logic ret_req_i,
  input wire logic vector_take_i,
  input wire logic [`IRQ_PC_W-1:0] vector_addr_i,
  input wire logic push_i,
  output logic boundary_o,
  output logic [`IRQ_PC_W-1:0] ret_addr_o,
  output logic ret_pulse_o,
  output logic [`IRQ_PC_W-1:0] pc_o
);
  logic phase_q;
  logic [3:0] depth_q;
  assign boundary_o = !phase_q;
  assign ret_addr_o = pc_o;
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      phase_q <= 1'b0;
      pc_o <= 21'h000100;
      depth_q <= 4'h0;
      ret_pulse_o <= 1'b0;
    end else begin
      // two-cycle instructions stretch boundary spacing
      phase_q <= two_cycle_i & !phase_q;
      // a return outside any handler is never issued
      ret_pulse_o <= ret_req_i && depth_q != 4'h0;
      depth_q <= depth_q + 4'(push_i) - 4'(ret_pulse_o);
      if (vector_take_i) pc_o <= vector_addr_i;
      else if (boundary_o) pc_o <= pc_o + 1'b1;
    end
  end
endmodule

// ===== verif/tb_two_level_interrupt_controller.sv
// self-checking bench for the two-level interrupt controller
`timescale 1ns/100ps
`include "irq_ctrl_cfg.svh"
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin mismatches++; \
  $display("unexpected t=%0t got %h exp %h", $time, g, e); end end
module tb_two_level_interrupt_controller;
  logic mclk_i = 0, resetn_i = 0, reg_wr_i = 0, reg_rd_i = 0;
  logic two_cycle_i = 0, ret_req_i = 0, boundary_o, ret_pulse_o, vector_take_o, push_o;
  logic [2:0] reg_addr_i = 0;
  logic [7:0] reg_wdata_i = 0, periph_event_i = 0, reg_rdata_o, acc, r;
  logic [1:0] ext_pin_i = 0;
  logic [20:0] ret_addr_o, vector_addr_o, push_data_o, pc_o;
  int mismatches = 0, check_count = 0, n;
  two_level_irq_ctrl u_two_level_irq_ctrl (.*, .ce_i(1'b1), .instr_boundary_i(boundary_o),
    .return_addr_i(ret_addr_o), .return_from_handler_i(ret_pulse_o));
  core_model u_core_model (.*, .vector_take_i(vector_take_o), .vector_addr_i(vector_addr_o),
    .push_i(push_o));
  always #5 mclk_i = ~mclk_i;
  function automatic logic [20:0] exp_vec(input logic lvl, input logic hi);
    return (lvl && !hi) ? `IRQ_VEC_LOW : `IRQ_VEC_HIGH;
  endfunction
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge mclk_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic chk_rd(input logic [2:0] a, input logic [7:0] e);
    @(posedge mclk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge mclk_i);
    reg_rd_i <= 1'b0;
    #1 `CHK(reg_rdata_o, e)
  endtask
  task automatic ev(input logic [7:0] v);
    @(posedge mclk_i);
    periph_event_i <= v;
    @(posedge mclk_i);
    periph_event_i <= 8'h00;
  endtask
  task automatic ret();
    @(posedge mclk_i);
    ret_req_i <= 1'b1;
    @(posedge mclk_i);
    ret_req_i <= 1'b0;
    repeat (2) @(posedge mclk_i);
  endtask
  task automatic take(input logic [20:0] e);
    for (int k = 0; k < 12 && vector_take_o !== 1'b1; k++) begin
      @(posedge mclk_i);
      #1;
    end
    if (vector_take_o !== 1'b1) begin
      mismatches++;
      wrap_up();
    end
    `CHK(vector_addr_o, e)
    `CHK(push_o, 1'b1)
    @(posedge mclk_i);
    #1 `CHK(pc_o, e)
  endtask
  task automatic no_take(input int c);
    repeat (c) begin
      @(posedge mclk_i);
      #1 `CHK(vector_take_o, 1'b0)
    end
  endtask
  initial begin
    void'($urandom(6));
    repeat (4) @(posedge mclk_i);
    resetn_i <= 1'b1;
    chk_rd(3'h1, 8'h00);
    chk_rd(3'h4, `IRQ_RST_PRIORITY);
    chk_rd(3'h6, 8'h00);
    acc = 8'h01;
    repeat (12) begin
      r = 8'($urandom) & `IRQ_PERIPH_MASK;
      ev(r);
      acc = acc | r;
    end
    ext_pin_i <= 2'b01;
    repeat (6) @(posedge mclk_i);
    chk_rd(3'h2, acc);
    r = 8'($urandom);
    wr(3'h3, r);
    chk_rd(3'h3, r);
    wr(3'h3, 8'h00);
    wr(3'h0, 8'hC0);
    no_take(4);
    chk_rd(3'h2, acc);
    wr(3'h0, 8'h00);
    wr(3'h2, 8'h00);
    ext_pin_i <= 2'b00;
    wr(3'h4, 8'h00);
    for (n = 0; n < 2; n++) begin
      two_cycle_i <= n[0];
      wr(3'h3, 8'h05);
      wr(3'h0, 8'h80);
      ev(8'h04);
      no_take(4);
      ext_pin_i <= 2'b01;
      take(exp_vec(1'b0, 1'b0));
      chk_rd(3'h0, 8'h00);
      wr(3'h2, 8'h00);
      ext_pin_i <= 2'b00;
      ret();
      chk_rd(3'h0, 8'h80);
    end
    wr(3'h1, 8'h80);
    wr(3'h4, 8'h04);
    wr(3'h3, 8'h0C);
    wr(3'h0, 8'hC0);
    ev(8'h08);
    take(exp_vec(1'b1, 1'b0));
    chk_rd(3'h0, 8'h80);
    ev(8'h04);
    take(exp_vec(1'b1, 1'b1));
    chk_rd(3'h5, 8'h03);
    wr(3'h2, 8'h00);
    wr(3'h0, 8'h40);
    ev(8'h08);
    no_take(6);
    wr(3'h2, 8'h00);
    ret();
    chk_rd(3'h0, 8'hC0);
    ret();
    wr(3'h0, 8'h00);
    wr(3'h2, 8'h0C);
    wr(3'h0, 8'hC0);
    take(exp_vec(1'b1, 1'b1));
    wrap_up();
  end
endmodule
